// File: drive_status_word_bank.sv
// Drive status word bank: read-only speed, constant speed and auxiliary motor
// words, plus five selectors for main status word bits 10..14.
// Assumes flag inputs come from logic on mclk; the run enable is a pin.
module drive_status_word_bank
  import drv_status_pkg::*;
#(
  parameter int OTHER_W   = 8,
  parameter int ZERO_TICK = ZERO_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Register port
  input  wire reg_req_type           req,
  output logic        [DATA_W-1:0]   rd_data_r,
  // Drive flags
  input  wire speed_in_type          speed_in,
  input  wire logic   [CONST_W-1:0]  const_sel,
  input  wire aux_in_type            aux_in,
  // Selector sources
  input  wire logic                  above_limit,
  input  wire logic                  ctrl_word_bit11,
  input  wire logic                  ext_run_enable_pin,
  input  wire logic   [OTHER_W-1:0]  other_bits,
  // Main status word bits 10..14
  output logic        [NSEL-1:0]     msw_bits_r
);

  localparam int TICK_W = $clog2(ZERO_TICK + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(ZERO_TICK - 1);

  logic [DATA_W-1:0]            speed_r;
  logic [DATA_W-1:0]            const_r;
  logic [DATA_W-1:0]            aux_r;
  logic [NSEL-1:0][DATA_W-1:0]  sel_r;
  logic [DATA_W-1:0]            zdelay_r;
  logic [TICK_W-1:0]            tick_cnt_r;
  logic [DATA_W-1:0]            zero_ms_r;
  logic                         run_en_meta_r;
  logic                         run_en_r;
  logic                         zero_met;
  logic [NSEL-1:0]              native_src;
  logic [NSEL-1:0]              sel_src;
  logic [DATA_W-1:0]            rd_nxt;

  // Pin crosses two flops before the selectors see it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_en_meta_r <= 1'b0;
      run_en_r      <= 1'b0;
    end else begin
      run_en_meta_r <= ext_run_enable_pin;
      run_en_r      <= run_en_meta_r;
    end
  end

  // Millisecond ticks counted only while continuously below the limit;
  // leaving the band restarts the whole delay.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
      zero_ms_r  <= '0;
    end else if (!speed_in.below_zero) begin
      tick_cnt_r <= '0;
      zero_ms_r  <= '0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
      if (zero_ms_r != {DATA_W{1'b1}}) begin
        zero_ms_r <= zero_ms_r + 16'h0001;
      end
    end else begin
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
    end
  end

  // Saturating ms count keeps a long stop from wrapping back under the delay
  assign zero_met = speed_in.below_zero && (zero_ms_r >= zdelay_r);

  // Status words track the drive flags; no write path reaches them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      speed_r <= '0;
    end else begin
      speed_r               <= '0;
      speed_r[SC_ZERO]      <= zero_met;
      speed_r[SC_FWD]       <= !speed_in.below_zero && !speed_in.reverse;
      speed_r[SC_REV]       <= !speed_in.below_zero && speed_in.reverse;
      speed_r[SC_WINDOW]    <= speed_in.out_of_window;
      speed_r[SC_EST_FB]    <= speed_in.est_feedback;
      speed_r[SC_ANY_CONST] <= |const_sel;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      const_r <= '0;
      aux_r   <= '0;
    end else begin
      const_r <= {{(DATA_W-CONST_W){1'b0}}, const_sel};
      aux_r   <= {{(DATA_W-AUX_W){1'b0}}, aux_in};
    end
  end

  // Writes land only in selector and delay registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_r    <= SEL_RST;
      zdelay_r <= ZDELAY_RST;
    end else if (req.wr) begin
      if (req.addr >= IDX_SEL10 && req.addr <= IDX_SEL14) begin
        sel_r[3'(req.addr - IDX_SEL10)] <= req.wdata;
      end else if (req.addr == IDX_ZDELAY) begin
        zdelay_r <= req.wdata;
      end
      // Speed, constant and aux indices fall through untouched
    end
  end

  // Sources behind code 2; bits 13 and 14 have none and read 0
  assign native_src = {1'b0, 1'b0, run_en_r, ctrl_word_bit11, above_limit};

  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : g_sel
      logic [DATA_W-1:0] other_idx;
      assign other_idx = sel_r[g] - SEL_OTHER_BASE;
      always_comb begin
        if (sel_r[g] == SEL_FALSE) begin
          sel_src[g] = 1'b0;
        end else if (sel_r[g] == SEL_TRUE) begin
          sel_src[g] = 1'b1;
        end else if (sel_r[g] == SEL_NATIVE) begin
          sel_src[g] = native_src[g];
        end else if (other_idx < DATA_W'(OTHER_W)) begin
          sel_src[g] = other_bits[other_idx[$clog2(OTHER_W)-1:0]];
        end else begin
          sel_src[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      msw_bits_r <= '0;
    end else begin
      msw_bits_r <= sel_src;
    end
  end

  // Read mux; unmapped indices answer zero
  always_comb begin
    rd_nxt = '0;
    case (req.addr)
      IDX_SPEED:  rd_nxt = speed_r;
      IDX_CONST:  rd_nxt = const_r;
      IDX_AUX:    rd_nxt = aux_r;
      IDX_ZDELAY: rd_nxt = zdelay_r;
      default: begin
        if (req.addr >= IDX_SEL10 && req.addr <= IDX_SEL14) begin
          rd_nxt = sel_r[3'(req.addr - IDX_SEL10)];
        end
      end
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= '0;
    end else if (req.rd) begin
      rd_data_r <= rd_nxt;
    end else begin
      rd_data_r <= '0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_ZERO_CAUSE: assert property (
    $rose(speed_r[SC_ZERO]) |-> $past(speed_in.below_zero) && $past(zero_ms_r) >= $past(zdelay_r)
  ) else $error("zero-speed bit set before the delay ran out");

  AST_ZERO_DROP: assert property (
    !speed_in.below_zero |=> !speed_r[SC_ZERO] && zero_ms_r == '0
  ) else $error("zero-speed state not cleared when leaving the band");

  AST_FWD: assert property (
    !speed_in.below_zero && !speed_in.reverse |=> speed_r[SC_FWD] && !speed_r[SC_REV]
  ) else $error("forward bit wrong");

  AST_REV: assert property (
    speed_in.below_zero |=> !speed_r[SC_FWD] && !speed_r[SC_REV]
  ) else $error("direction bit set below the zero-speed limit");

  AST_WIN_EST: assert property (
    ##1 speed_r[SC_WINDOW] == $past(speed_in.out_of_window) && speed_r[SC_EST_FB] == $past(speed_in.est_feedback)
  ) else $error("window or estimate bit wrong");

  AST_ANY_CONST: assert property (
    ##1 speed_r[SC_ANY_CONST] == |const_r[CONST_W-1:0] && speed_r[15:10] == '0
  ) else $error("any-constant bit disagrees with constant word");

  AST_CONST: assert property (
    ##1 const_r == {9'h000, $past(const_sel)}
  ) else $error("constant speed word wrong");

  AST_AUX: assert property (
    ##1 aux_r == {10'h000, $past(aux_in)}
  ) else $error("aux word wrong");

  AST_RO: assert property (
    req.wr && req.addr <= IDX_AUX |=> $stable(sel_r) && $stable(zdelay_r)
  ) else $error("status word write reached a register");

  AST_SEL_CONST: assert property (
    sel_r[0] == SEL_TRUE && sel_r[3] == SEL_FALSE |=> msw_bits_r[0] && !msw_bits_r[3]
  ) else $error("constant selection not honoured");

  AST_SEL_RUN: assert property (
    sel_r[2] == SEL_NATIVE |=> msw_bits_r[2] == $past(run_en_meta_r, 2)
  ) else $error("run enable selection wrong");

  AST_LATENCY: assert property (
    ##1 msw_bits_r == $past(sel_src)
  ) else $error("status bits not one cycle behind sources");

  AST_READ: assert property (
    !req.rd |=> rd_data_r == '0
  ) else $error("read data outside the answer cycle");

  // Zero-speed timing: bit 0 never leads the counters
  AST_ZERO_PREV: assert property (
    speed_r[SC_ZERO] |-> $past(speed_in.below_zero)
  ) else $error("zero-speed bit set without the drive below the limit");

  AST_ZERO_STEP: assert property (
    speed_in.below_zero && tick_cnt_r == TICK_LAST && zero_ms_r != 16'hffff |=> zero_ms_r == $past(zero_ms_r) + 16'h0001
  ) else $error("millisecond count did not step on the tick");

  AST_TICK_RANGE: assert property (
    tick_cnt_r <= TICK_LAST
  ) else $error("tick counter ran past its last value");

  AST_ZERO_EARLY: assert property (
    speed_in.below_zero && zero_ms_r < zdelay_r |=> !speed_r[SC_ZERO]
  ) else $error("zero-speed bit set before the delay");

  AST_ZERO_SET: assert property (
    speed_in.below_zero && zero_ms_r >= zdelay_r |=> speed_r[SC_ZERO]
  ) else $error("zero-speed bit missing after the delay");

  AST_ZERO_VS_DIR: assert property (
    !(speed_r[SC_ZERO] && (speed_r[SC_FWD] || speed_r[SC_REV]))
  ) else $error("zero-speed bit together with a direction bit");

  AST_ZDELAY_WRITE: assert property (
    req.wr && req.addr == IDX_ZDELAY |=> zdelay_r == $past(req.wdata)
  ) else $error("zero-speed delay write lost");

  // Direction, reserved and any-constant bits
  AST_REV_DIR: assert property (
    !speed_in.below_zero && speed_in.reverse |=> speed_r[SC_REV] && !speed_r[SC_FWD]
  ) else $error("reverse bit wrong");

  AST_FWD_DROP: assert property (
    speed_in.reverse |=> !speed_r[SC_FWD]
  ) else $error("forward bit set while turning in reverse");

  AST_REV_DROP: assert property (
    !speed_in.reverse |=> !speed_r[SC_REV]
  ) else $error("reverse bit set while turning forward");

  AST_DIR_EXCL: assert property (
    !(speed_r[SC_FWD] && speed_r[SC_REV])
  ) else $error("both direction bits set");

  AST_SPEED_RSVD: assert property (
    speed_r[15:8] == 8'h00 && speed_r[6:5] == 2'h0
  ) else $error("unused speed control bits set");

  AST_ANY_CONST_SRC: assert property (
    ##1 speed_r[SC_ANY_CONST] == |$past(const_sel)
  ) else $error("any-constant bit disagrees with the selection flags");

  // Constant and auxiliary words
  AST_CONST_RSVD: assert property (
    const_r[15:7] == 9'h000
  ) else $error("reserved constant speed bits set");

  AST_AUX_RSVD: assert property (
    aux_r[15:6] == 10'h000
  ) else $error("reserved aux bits set");

  AST_AUX_HOLD: assert property (
    ##1 aux_r[0] == $past(aux_in.dc_hold) && aux_r[1] == $past(aux_in.post_magnetize)
        && aux_r[2] == $past(aux_in.pre_heat)
  ) else $error("hold, magnetizing or heating bit misplaced");

  AST_AUX_MOTOR: assert property (
    ##1 aux_r[3] == $past(aux_in.magnet_motor_soft_start_flag) && aux_r[4] == $past(aux_in.rotor_pos_known)
        && aux_r[5] == $past(aux_in.dc_brake)
  ) else $error("soft start, rotor or brake bit misplaced");

  // Selector writes and sources; codes past the last source read 0
  AST_SEL_WRITE: assert property (
    req.wr && req.addr == IDX_SEL10 |=> sel_r[0] == $past(req.wdata)
  ) else $error("bit-10 selector write lost");

  AST_SEL14_WRITE: assert property (
    req.wr && req.addr == IDX_SEL14 |=> sel_r[4] == $past(req.wdata)
  ) else $error("bit-14 selector write lost");

  AST_SEL_ABOVE: assert property (
    sel_r[0] == SEL_NATIVE |=> msw_bits_r[0] == $past(above_limit)
  ) else $error("above-limit selection wrong");

  AST_SEL_CTRL: assert property (
    sel_r[1] == SEL_NATIVE |=> msw_bits_r[1] == $past(ctrl_word_bit11)
  ) else $error("control word bit selection wrong");

  AST_SEL_ONE11: assert property (
    sel_r[1] == SEL_TRUE |=> msw_bits_r[1]
  ) else $error("bit 11 constant one not honoured");

  AST_SEL_ZERO12: assert property (
    sel_r[2] == SEL_FALSE |=> !msw_bits_r[2]
  ) else $error("bit 12 constant zero not honoured");

  AST_SEL_FREE13: assert property (
    sel_r[3] == SEL_NATIVE |=> !msw_bits_r[3]
  ) else $error("bit 13 has no native source but read one");

  AST_SEL14_ZERO: assert property (
    sel_r[4] == SEL_FALSE || sel_r[4] == SEL_NATIVE |=> !msw_bits_r[4]
  ) else $error("bit 14 not zero");

  AST_SEL14_TRUE: assert property (
    sel_r[4] == SEL_TRUE |=> msw_bits_r[4]
  ) else $error("bit 14 constant one not honoured");

  AST_SEL_OTHER: assert property (
    sel_r[0] == SEL_OTHER_BASE |=> msw_bits_r[0] == $past(other_bits[0])
  ) else $error("other source selection wrong");

  AST_SEL_RANGE: assert property (
    sel_r[0] >= SEL_OTHER_BASE + DATA_W'(OTHER_W) |=> !msw_bits_r[0]
  ) else $error("out-of-range source code not read as zero");

  // Register reads
  AST_READ_WORD: assert property (
    req.rd && req.addr == IDX_SPEED |=> rd_data_r == $past(speed_r)
  ) else $error("speed control word read wrong");

  AST_READ_SEL: assert property (
    req.rd && req.addr == IDX_SEL10 + 4'h1 |=> rd_data_r == $past(sel_r[1])
  ) else $error("bit-11 selector read wrong");

  AST_READ_UNMAPPED: assert property (
    req.rd && req.addr > IDX_ZDELAY |=> rd_data_r == '0
  ) else $error("unmapped index read not zero");

endmodule

// File: drive_status_word_bank_bench.sv
// Self-checking bench for the drive status word bank.
// Assumes the bank's plain strobe register port and a shortened zero-speed tick of 4 cycles.
module drive_status_word_bank_bench import drv_status_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk = 1'b0;
  logic              resetn = 1'b0;
  reg_req_type       req = '0;
  logic [DATA_W-1:0] rd_data_r;
  speed_in_type      speed_in = '0;
  logic [CONST_W-1:0] const_sel = '0;
  aux_in_type        aux_in = '0;
  logic              above_limit = 1'b0;
  logic              ctrl_word_bit11 = 1'b0;
  logic              ext_run_enable_pin = 1'b0;
  logic [7:0]        other_bits = 8'h00;
  logic [NSEL-1:0]   msw_bits_r;
  int                fail_count = 0;
  int                checks = 0;

  always #2 mclk = ~mclk;

  drive_status_word_bank #(.OTHER_W(8), .ZERO_TICK(4)) drive_status_word_bank_i (
    .mclk(mclk), .resetn(resetn), .req(req), .rd_data_r(rd_data_r),
    .speed_in(speed_in), .const_sel(const_sel), .aux_in(aux_in),
    .above_limit(above_limit), .ctrl_word_bit11(ctrl_word_bit11),
    .ext_run_enable_pin(ext_run_enable_pin), .other_bits(other_bits), .msw_bits_r(msw_bits_r));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask

  // Data is sampled in the single cycle where it stands
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    req <= '0;
    #1 d = rd_data_r;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Four cycles cover the two-flop synchroniser on the run enable pin
  task automatic mchk(input int i, input logic e);
    repeat (4) @(posedge mclk);
    #1 chk({15'h0000, msw_bits_r[i]}, {15'h0000, e});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    logic [15:0] d;
    logic [3:0]  sa;
    int          n;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < NSEL; i++) begin
      rdc(IDX_SEL10 + 4'(i), SEL_RST[i]);
    end
    rdc(IDX_ZDELAY, 16'h0000);
    wr(4'hf, 16'hffff);
    rdc(4'hf, 16'h0000);
    $display("test reset values done");

    for (int k = 0; k < 7; k++) begin
      @(posedge mclk);
      speed_in <= '{below_zero: 1'b0, reverse: 1'b0, out_of_window: 1'b1, est_feedback: 1'b1};
      const_sel <= 7'(1 << k);
      aux_in <= (k < 6) ? 6'(1 << k) : 6'h00;
      rdc(IDX_CONST, 16'(1 << k));
      rdc(IDX_SPEED, 16'h009a);
      rdc(IDX_AUX, (k < 6) ? 16'(1 << k) : 16'h0000);
    end
    @(posedge mclk);
    speed_in <= '{below_zero: 1'b0, reverse: 1'b1, out_of_window: 1'b0, est_feedback: 1'b0};
    const_sel <= 7'h00;
    aux_in <= 6'h3f;
    wr(IDX_SPEED, 16'hffff);
    wr(IDX_CONST, 16'hffff);
    wr(IDX_AUX, 16'hffff);
    rdc(IDX_SPEED, 16'h0004);
    rdc(IDX_CONST, 16'h0000);
    rdc(IDX_AUX, 16'h003f);
    rd(IDX_CONST, d);
    @(posedge mclk);
    #1 chk(rd_data_r, 16'h0000);
    $display("test status words done");

    wr(IDX_ZDELAY, 16'h0002);
    @(posedge mclk);
    speed_in <= '{below_zero: 1'b1, reverse: 1'b0, out_of_window: 1'b0, est_feedback: 1'b0};
    rdc(IDX_SPEED, 16'h0000);
    n = 0;
    do begin
      rd(IDX_SPEED, d);
      n++;
    end while (d !== 16'h0001 && n < 20);
    chk(d, 16'h0001);
    // Two ms of four cycles each, polled every second cycle
    chk(16'(n), 16'h0004);
    @(posedge mclk);
    speed_in <= '0;
    rdc(IDX_SPEED, 16'h0002);
    // Leaving the band must restart the whole delay
    @(posedge mclk);
    speed_in <= '{below_zero: 1'b1, reverse: 1'b0, out_of_window: 1'b0, est_feedback: 1'b0};
    rdc(IDX_SPEED, 16'h0000);
    $display("test zero speed done");

    @(posedge mclk);
    other_bits <= 8'ha5;
    for (int i = 0; i < NSEL; i++) begin
      sa = IDX_SEL10 + 4'(i);
      wr(sa, SEL_FALSE);
      mchk(i, 1'b0);
      wr(sa, SEL_TRUE);
      mchk(i, 1'b1);
      wr(sa, SEL_OTHER_BASE + 16'(i));
      mchk(i, other_bits[i]);
      wr(sa, SEL_OTHER_BASE + 16'h0007);
      mchk(i, 1'b1);
      wr(sa, SEL_OTHER_BASE + 16'h0008);
      mchk(i, 1'b0);
      rdc(sa, SEL_OTHER_BASE + 16'h0008);
      for (int v = 0; v < 2; v++) begin
        @(posedge mclk);
        above_limit <= v[0];
        ctrl_word_bit11 <= !v[0];
        ext_run_enable_pin <= v[0];
        wr(sa, SEL_NATIVE);
        mchk(i, (i < 3) ? ((i == 1) ^ v[0]) : 1'b0);
      end
    end
    @(posedge mclk);
    above_limit <= 1'b0;
    #1 chk({15'h0000, msw_bits_r[0]}, 16'h0001);
    @(posedge mclk);
    #1 chk({15'h0000, msw_bits_r[0]}, 16'h0000);
    $display("test selectors done");
    test_done();
  end
endmodule

// File: drv_status_pkg.sv
// Constants, register indices and carrier types for the drive status word bank.
// Assumes one 250 MHz clock and a plain strobe-based register port.
package drv_status_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] IDX_SPEED  = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_CONST  = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_AUX    = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_SEL10  = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_SEL14  = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_ZDELAY = 4'h8;

  // Speed control word field positions
  localparam int SC_ZERO      = 0;
  localparam int SC_FWD       = 1;
  localparam int SC_REV       = 2;
  localparam int SC_WINDOW    = 3;
  localparam int SC_EST_FB    = 4;
  localparam int SC_ANY_CONST = 7;

  localparam int CONST_W = 7;
  localparam int AUX_W   = 6;

  // Main status word bits driven by the selectors
  localparam int MSW_SEL_FIRST = 10;
  localparam int NSEL          = 5;

  // Selector codes
  localparam logic [DATA_W-1:0] SEL_FALSE      = 16'h0000;
  localparam logic [DATA_W-1:0] SEL_TRUE       = 16'h0001;
  localparam logic [DATA_W-1:0] SEL_NATIVE     = 16'h0002;
  localparam logic [DATA_W-1:0] SEL_OTHER_BASE = 16'h0003;

  // Reset values, index 0 is bit 10
  localparam logic [NSEL-1:0][DATA_W-1:0] SEL_RST = {16'h0000, 16'h0000, 16'h0002, 16'h0002, 16'h0002};
  localparam logic [DATA_W-1:0] ZDELAY_RST = 16'h0000;

  // Zero-speed delay counts in ticks of one millisecond
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int ZERO_TICK_MS     = 1;
  localparam int ZERO_TICK_CYCLES = ZERO_TICK_MS * 1000000000 / CLK_PERIOD_PS;

  typedef struct packed {
    logic below_zero;
    logic reverse;
    logic out_of_window;
    logic est_feedback;
  } speed_in_type;

  // Bit 0 is dc_hold
  typedef struct packed {
    logic dc_brake;
    logic rotor_pos_known;
    logic magnet_motor_soft_start_flag;
    logic pre_heat;
    logic post_magnetize;
    logic dc_hold;
  } aux_in_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

endpackage
